// >>> rtl/mpb_pkg.sv
// Function
// [R1] Fixed priority first, second, alternate last two.
// [R2] Fast module serves one statically selected port.
// [R3] Later request waits until module is free.
// [R4] Drive select lines, request cycle, read/write function.
// [R5] Free module acknowledges within window; otherwise wait.
// [R6] Capture bus data on read restart.
// [R7] Module finishes its cycle without holding processor.
// [R8] Write data goes with request; acknowledge releases.
// [R9] Read plus write selects read-pause-write.
// [R10] Pause: send result with write restart, then release.
// [R11] Bus released once data taken or delivered.
// [R12] Split address into module and word fields.
// [R13] Four top bits plus one chosen low bit.
// [R14] Each port answers its own select values.
// [R15] All-zero high bits assert fast block signal.
// [R16] Fifth select line chooses interleave block size.
// [R17] Interleaved word location uses one select bit.
// [R18] Protection overlap flags error, suppresses cycle.
// [R19] Upper nine bits ORed with relocation.
// [R20] Core cycle 2 us, fast cycle 0.4 us.
// [R21] First sixteen locations double as accumulators.
// [R22] Core read data ready 0.8 us after start.
// [R23] Write-only keeps buffer through internal read.
// [R24] Pause delays internal write until restart.
// [R25] Hold request lines stable until acknowledge.
// [R26] Protection error sticky until acknowledged.
package mpb_pkg;
  localparam int ADDR_W = 18;
  localparam int WORD_W = 36;
  localparam int SEL_W = 5;
  localparam int WADDR_W = 14;
  localparam int PROT_W = 9;
  localparam int FIFTH_W = 4;
  localparam int HI_SEL_LSB = 14;
  localparam int FAST_ADDR_LSB = 4;
  localparam int CLK_NS = 4;
  localparam int ACK_NS = 400;
  localparam int ACK_CYC = ACK_NS / CLK_NS;
  localparam int CNT_W = 7;

  typedef enum logic [2:0] {
    MPB_IDLE,
    MPB_REQ,
    MPB_RDW,
    MPB_PAUSE,
    MPB_WRR
  } mpb_st_e;
endpackage : mpb_pkg

// >>> rtl/mpb_addr_map.sv
`timescale 1ns/1ps
module mpb_addr_map
  import mpb_pkg::*;
(
  // Requested address and protection settings
  input wire logic [mpb_pkg::ADDR_W-1:0] addr_i,
  input wire logic prot_en_i,
  input wire logic [mpb_pkg::PROT_W-1:0] prot_i,
  input wire logic [mpb_pkg::PROT_W-1:0] reloc_i,
  input wire logic [mpb_pkg::FIFTH_W-1:0] fifth_i,
  // Bus fields
  output logic [mpb_pkg::SEL_W-1:0] sel_o,
  output logic [mpb_pkg::WADDR_W-1:0] waddr_o,
  output logic fast_o,
  output logic viol_o
);
  logic [ADDR_W-1:0] phys;
  logic fifth_bit;

  always_comb
  begin
    viol_o = prot_en_i && ((addr_i[ADDR_W-1:PROT_W] & prot_i) != '0); // [R18]
    phys = addr_i;
    if (prot_en_i)
    begin
      phys = {addr_i[ADDR_W-1:PROT_W] | reloc_i, addr_i[PROT_W-1:0]}; // [R19]
    end
    // An out-of-range choice falls back to bit zero rather than an undefined select.
    fifth_bit = (int'(fifth_i) < WADDR_W) ? phys[fifth_i] : phys[0];
    sel_o = {phys[ADDR_W-1:HI_SEL_LSB], fifth_bit}; // [R13]
    waddr_o = phys[WADDR_W-1:0]; // [R12]
    fast_o = (phys[ADDR_W-1:FAST_ADDR_LSB] == '0); // [R15]
  end
endmodule : mpb_addr_map

// >>> rtl/mpb_host.sv
`timescale 1ns/1ps
module mpb_host
  import mpb_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // User request side
  input wire logic req_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [mpb_pkg::ADDR_W-1:0] addr_i,
  input wire logic [mpb_pkg::WORD_W-1:0] wdata_i,
  input wire logic wr_restart_i,
  output logic busy_o,
  output logic pause_o,
  output logic done_o,
  output logic slow_o,
  output logic [mpb_pkg::WORD_W-1:0] rdata_o,
  // Protection and address selection
  input wire logic prot_en_i,
  input wire logic [mpb_pkg::PROT_W-1:0] prot_i,
  input wire logic [mpb_pkg::PROT_W-1:0] reloc_i,
  input wire logic [mpb_pkg::FIFTH_W-1:0] fifth_i,
  input wire logic err_ack_i,
  output logic err_o,
  // Memory bus
  output logic mem_rq_o,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic mem_fast_o,
  output logic [mpb_pkg::SEL_W-1:0] mem_sel_o,
  output logic [mpb_pkg::WADDR_W-1:0] mem_addr_o,
  output logic [mpb_pkg::WORD_W-1:0] mem_data_o,
  output logic mem_data_oe_o,
  output logic mem_wr_restart_o,
  input wire logic mem_ack_i,
  input wire logic mem_rd_restart_i,
  input wire logic [mpb_pkg::WORD_W-1:0] mem_data_i
);
  import mpb_pkg::*;

  typedef struct packed {
    mpb_st_e st;
    logic [SEL_W-1:0] sel;
    logic [WADDR_W-1:0] waddr;
    logic rd;
    logic wr;
    logic fast;
    logic [WORD_W-1:0] wd;
    logic [WORD_W-1:0] rdd;
    logic done;
    logic err;
    logic slow;
    logic [CNT_W-1:0] wcnt;
  } mpb_state_s;

  mpb_state_s s_r;
  mpb_state_s s_nxt;
  logic [SEL_W-1:0] map_sel;
  logic [WADDR_W-1:0] map_waddr;
  logic map_fast;
  logic map_viol;

  mpb_addr_map u_map (
    .addr_i(addr_i),
    .prot_en_i(prot_en_i),
    .prot_i(prot_i),
    .reloc_i(reloc_i),
    .fifth_i(fifth_i),
    .sel_o(map_sel),
    .waddr_o(map_waddr),
    .fast_o(map_fast),
    .viol_o(map_viol)
  );

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (err_ack_i)
    begin
      s_nxt.err = 1'b0;
    end
    case (s_r.st)
      MPB_IDLE:
      begin
        if (req_i && (rd_i || wr_i))
        begin
          if (map_viol)
          begin
            s_nxt.err = 1'b1; // [R18] [R26]
          end
          else
          begin
            s_nxt.st = MPB_REQ; // [R4]
            s_nxt.sel = map_sel;
            s_nxt.waddr = map_waddr;
            s_nxt.fast = map_fast;
            s_nxt.rd = rd_i; // [R9]
            s_nxt.wr = wr_i;
            s_nxt.wd = wdata_i; // [R8]
            s_nxt.wcnt = '0;
            s_nxt.slow = 1'b0;
          end
        end
      end
      MPB_REQ:
      begin
        // A busy module simply delays its acknowledge; the port keeps waiting.
        if (mem_ack_i)
        begin
          s_nxt.st = s_r.rd ? MPB_RDW : MPB_IDLE; // [R5] [R11]
          s_nxt.done = !s_r.rd; // [R8]
        end
        else if (s_r.wcnt == CNT_W'(ACK_CYC))
        begin
          s_nxt.slow = 1'b1; // [R5]
        end
        else
        begin
          s_nxt.wcnt = s_r.wcnt + 1'b1;
        end
      end
      MPB_RDW:
      begin
        if (mem_rd_restart_i)
        begin
          s_nxt.rdd = mem_data_i; // [R6]
          s_nxt.st = s_r.wr ? MPB_PAUSE : MPB_IDLE; // [R10]
          s_nxt.done = !s_r.wr;
        end
      end
      MPB_PAUSE:
      begin
        if (wr_restart_i)
        begin
          s_nxt.wd = wdata_i; // [R10]
          s_nxt.st = MPB_WRR;
        end
      end
      MPB_WRR:
      begin
        s_nxt.st = MPB_IDLE; // [R10]
        s_nxt.done = 1'b1;
      end
      default:
      begin
        s_nxt.st = MPB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_r <= '{st: MPB_IDLE, default: '0};
    end
    else if (ce_i)
    begin
      s_r <= s_nxt;
    end
  end

  // Lines are driven from held registers so they stay put until acknowledge.
  assign mem_rq_o = (s_r.st == MPB_REQ); // [R25]
  assign mem_rd_o = mem_rq_o && s_r.rd;
  assign mem_wr_o = mem_rq_o && s_r.wr;
  assign mem_fast_o = mem_rq_o && s_r.fast;
  assign mem_sel_o = s_r.sel;
  assign mem_addr_o = s_r.waddr;
  assign mem_data_o = s_r.wd;
  assign mem_data_oe_o = (mem_rq_o && s_r.wr && !s_r.rd) || (s_r.st == MPB_WRR); // [R8]
  assign mem_wr_restart_o = (s_r.st == MPB_WRR);
  assign busy_o = (s_r.st != MPB_IDLE);
  assign pause_o = (s_r.st == MPB_PAUSE);
  assign done_o = s_r.done;
  assign slow_o = s_r.slow;
  assign rdata_o = s_r.rdd;
  assign err_o = s_r.err;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_rpw_read;
    ce_i && s_r.st == MPB_RDW && s_r.wr && mem_rd_restart_i;
  endsequence

  sequence s_result_sent;
    ce_i && pause_o && wr_restart_i;
  endsequence

  a_req_stable_lines: assert property (mem_rq_o && !mem_ack_i |=> // [R25]
    $stable(mem_sel_o) && $stable(mem_addr_o) && $stable(mem_rd_o) && $stable(mem_wr_o))
    else $error("Request lines changed before acknowledge.");
  a_req_has_func: assert property (mem_rq_o |-> (mem_rd_o || mem_wr_o)) // [R4]
    else $error("Request without function.");
  a_write_data_drive: assert property (mem_wr_o && !mem_rd_o |-> mem_data_oe_o) // [R8]
    else $error("Write request without data.");
  // A new request may follow at once, so only the cycle after the acknowledge is free of it.
  a_ack_release: assert property (ce_i && mem_rq_o && mem_ack_i |=> !mem_rq_o && !mem_data_oe_o) // [R11]
    else $error("Bus not released after acknowledge.");
  a_read_capture: assert property (ce_i && s_r.st == MPB_RDW && mem_rd_restart_i // [R6]
    |=> rdata_o == $past(mem_data_i))
    else $error("Read data not captured.");
  a_rpw_pause: assert property (s_rpw_read |=> pause_o) // [R10]
    else $error("Read-pause-write did not pause.");
  a_rpw_restart: assert property (s_result_sent |=> mem_wr_restart_o && mem_data_oe_o
    ##1 !mem_wr_restart_o && done_o) // [R10]
    else $error("Write restart not sent.");
  a_viol_no_cycle: assert property (ce_i && !busy_o && req_i && map_viol && (rd_i || wr_i)
    |=> err_o && !mem_rq_o) // [R18]
    else $error("Protected access not suppressed.");
  a_fast_flag: assert property (mem_rq_o |-> // [R15]
    mem_fast_o == (mem_sel_o[SEL_W-1:1] == '0 && mem_addr_o[WADDR_W-1:FAST_ADDR_LSB] == '0))
    else $error("Fast block flag wrong.");
  a_err_sticky: assert property (err_o && !err_ack_i |=> err_o) // [R26]
    else $error("Error flag dropped without acknowledge.");
  a_ce_freeze_state: assert property (!ce_i |=> $stable(s_r))
    else $error("State changed while clock enable was low.");
endmodule : mpb_host

// >>> verification/mpb_mem_model.sv
`timescale 1ns/1ps
module mpb_mem_model
  import mpb_pkg::*;
(
  // Bus from the host
  input wire logic clk_i,
  input wire logic rq_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic fast_i,
  input wire logic [mpb_pkg::SEL_W-1:0] sel_i,
  input wire logic [mpb_pkg::WADDR_W-1:0] addr_i,
  input wire logic [mpb_pkg::WORD_W-1:0] data_i,
  input wire logic wr_restart_i,
  // Answers
  output logic ack_o,
  output logic rd_restart_o,
  output logic [mpb_pkg::WORD_W-1:0] data_o
);
  logic [WORD_W-1:0] mem [logic [19:0]];
  logic [19:0] k;
  logic r;
  logic w;
  int ack_dly = 2;
  initial
  begin
    ack_o = 1'h0;
    rd_restart_o = 1'h0;
    data_o = '0;
    forever
    begin
      @(posedge clk_i);
      if (rq_i)
      begin
        // One request at a time, so a busy module simply answers later.
        k = {fast_i, sel_i, addr_i};
        r = rd_i;
        w = wr_i;
        repeat (ack_dly) @(posedge clk_i);
        #1 ack_o = 1'h1;
        if (!r)
          mem[k] = data_i;
        @(posedge clk_i);
        #1 ack_o = 1'h0;
        if (r)
        begin
          repeat (3) @(posedge clk_i);
          #1 rd_restart_o = 1'h1;
          data_o = mem.exists(k) ? mem[k] : '0;
          @(posedge clk_i);
          #1 rd_restart_o = 1'h0;
          data_o = ~data_o;
          for (int i = 0; i < 200 && w && !wr_restart_i; i++) @(posedge clk_i);
          if (w)
            mem[k] = data_i;
        end
      end
    end
  end
endmodule : mpb_mem_model

// >>> verification/multiport_memory_bus_interface_tb.sv
`timescale 1ns/1ps
module multiport_memory_bus_interface_tb;
  import mpb_pkg::*;
  typedef struct {
    logic r; logic w; logic [17:0] a; logic [35:0] d; logic [3:0] f;
    logic [4:0] sel; logic [13:0] wa; logic fast;
  } mpb_row_s;
  logic clk_i, rst_i, ce_i, req_i, rd_i, wr_i, wr_restart_i, prot_en_i, err_ack_i;
  logic busy_o, pause_o, done_o, slow_o, err_o, mem_rq_o, mem_rd_o, mem_wr_o;
  logic mem_fast_o, mem_data_oe_o, mem_wr_restart_o, mem_ack_i, mem_rd_restart_i;
  logic [17:0] addr_i;
  logic [35:0] wdata_i, rdata_o, mem_data_o, mem_data_i;
  logic [8:0] prot_i, reloc_i;
  logic [3:0] fifth_i;
  logic [4:0] mem_sel_o, sel_c;
  logic [13:0] mem_addr_o, wa_c;
  logic fa_c;
  int err_count = 0;
  int num_checks = 0;
  // Writes precede reads so every read has a known value to return.
  mpb_row_s rows [10] = '{
    '{1'h0, 1'h1, 18'h24567, 36'h123456789, 4'h0, 5'h13, 14'h0567, 1'h0},
    '{1'h1, 1'h0, 18'h24567, 36'h123456789, 4'h0, 5'h13, 14'h0567, 1'h0},
    '{1'h1, 1'h1, 18'h24567, 36'h987654321, 4'h0, 5'h13, 14'h0567, 1'h0},
    '{1'h1, 1'h0, 18'h24567, 36'h987654321, 4'h0, 5'h13, 14'h0567, 1'h0},
    '{1'h0, 1'h1, 18'h0000f, 36'h0000000aa, 4'h0, 5'h01, 14'h000f, 1'h1},
    '{1'h1, 1'h0, 18'h0000f, 36'h0000000aa, 4'h0, 5'h01, 14'h000f, 1'h1},
    '{1'h0, 1'h1, 18'h00010, 36'h000000005, 4'h4, 5'h01, 14'h0010, 1'h0},
    '{1'h1, 1'h0, 18'h00010, 36'h000000005, 4'h4, 5'h01, 14'h0010, 1'h0},
    '{1'h0, 1'h1, 18'h02000, 36'h000000007, 4'hd, 5'h01, 14'h2000, 1'h0},
    '{1'h1, 1'h0, 18'h24567, 36'h987654321, 4'hf, 5'h13, 14'h0567, 1'h0}};
  mpb_host dut_u (.clk_i, .rst_i, .ce_i, .req_i, .rd_i, .wr_i, .addr_i,
    .wdata_i, .wr_restart_i, .busy_o, .pause_o, .done_o, .slow_o, .rdata_o,
    .prot_en_i, .prot_i, .reloc_i, .fifth_i, .err_ack_i, .err_o, .mem_rq_o,
    .mem_rd_o, .mem_wr_o, .mem_fast_o, .mem_sel_o, .mem_addr_o, .mem_data_o,
    .mem_data_oe_o, .mem_wr_restart_o, .mem_ack_i, .mem_rd_restart_i, .mem_data_i);
  mpb_mem_model mem_u (.clk_i, .rq_i(mem_rq_o), .rd_i(mem_rd_o), .wr_i(mem_wr_o),
    .fast_i(mem_fast_o), .sel_i(mem_sel_o), .addr_i(mem_addr_o),
    .data_i(mem_data_o), .wr_restart_i(mem_wr_restart_o), .ack_o(mem_ack_i),
    .rd_restart_o(mem_rd_restart_i), .data_o(mem_data_i));
  task automatic end_sim();
    if (err_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'h1)
    begin
      err_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic run_op(input logic r, input logic w, input logic [17:0] a,
      input logic [35:0] d, input logic [3:0] f);
    int n;
    {rd_i, wr_i, addr_i, wdata_i, fifth_i, req_i} = {r, w, a, d, f, 1'h1};
    n = 0;
    do
    begin
      @(posedge clk_i);
      #1;
      req_i = 1'h0;
      wr_restart_i = pause_o;
      if (mem_rq_o === 1'h1)
        {sel_c, wa_c, fa_c} = {mem_sel_o, mem_addr_o, mem_fast_o};
      n++;
    end
    while (n < 400 && done_o !== 1'h1 && err_o !== 1'h1);
    if (n == 400)
    begin
      chk(1'h0, "timeout");
      end_sim();
    end
  endtask : run_op
  initial
  begin
    clk_i = 1'h0;
    forever #2 clk_i = ~clk_i;
  end
  initial
  begin
    {rst_i, req_i, rd_i, wr_i, wr_restart_i, prot_en_i, err_ack_i} = 7'h40;
    ce_i = 1'h1;
    {addr_i, wdata_i, prot_i, reloc_i, fifth_i} = '0;
    repeat (10) @(posedge clk_i);
    #1 rst_i = 1'h0;
    chk(busy_o === 1'h0 && mem_rq_o === 1'h0 && err_o === 1'h0, "reset");
    foreach (rows[i])
    begin
      run_op(rows[i].r, rows[i].w, rows[i].a, rows[i].d, rows[i].f);
      chk({sel_c, wa_c, fa_c} === {rows[i].sel, rows[i].wa, rows[i].fast}, "addr");
      if (rows[i].r && !rows[i].w)
        chk(rdata_o === rows[i].d, "read data");
    end
    {prot_en_i, prot_i, reloc_i} = {1'h1, 9'h100, 9'h003};
    run_op(1'h0, 1'h1, 18'h00434, 36'h000000055, 4'h0);
    chk({sel_c, wa_c, err_o} === {5'h00, 14'h0634, 1'h0}, "relocation");
    sel_c = 5'h1f;
    run_op(1'h1, 1'h0, 18'h24567, 36'h0, 4'h0);
    chk(err_o === 1'h1 && sel_c === 5'h1f, "violation");
    repeat (3) @(posedge clk_i);
    #1;
    chk(err_o === 1'h1, "sticky");
    err_ack_i = 1'h1;
    @(posedge clk_i);
    #1;
    err_ack_i = 1'h0;
    chk(err_o === 1'h0, "error clear");
    prot_en_i = 1'h0;
    // A request held while the enable is low must not be taken.
    ce_i = 1'h0;
    {req_i, rd_i, wr_i} = 3'h5;
    repeat (3) @(posedge clk_i);
    #1;
    chk(busy_o === 1'h0 && mem_rq_o === 1'h0, "clock enable hold");
    ce_i = 1'h1;
    @(posedge clk_i);
    #1 {req_i, rst_i} = 2'h1;
    chk(busy_o === 1'h1 && mem_rq_o === 1'h1, "request after enable");
    repeat (2) @(posedge clk_i);
    #1 rst_i = 1'h0;
    chk(busy_o === 1'h0 && mem_rq_o === 1'h0 && done_o === 1'h0, "mid reset");
    // Let the memory model finish the cycle that the reset cut off.
    repeat (12) @(posedge clk_i);
    #1;
    mem_u.ack_dly = 110;
    run_op(1'h0, 1'h1, 18'h24567, 36'h1, 4'h0);
    chk(slow_o === 1'h1, "slow");
    mem_u.ack_dly = 2;
    run_op(1'h1, 1'h0, 18'h24567, 36'h0, 4'h0);
    chk(rdata_o === 36'h1 && slow_o === 1'h0, "slow clear");
    end_sim();
  end
endmodule : multiport_memory_bus_interface_tb
